// >>> design/ossq_deglitch.sv
// ossq_deglitch: rejects short low pulses on the external reset input
// assumes the pin is already synchronous to sys_clk
`timescale 1ns/1ps
module ossq_deglitch
    import ossq_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    ossq_rst_if.filt  rif
);
    // ------------------------------------------------------------------
    // low-time counter
    // ------------------------------------------------------------------
    logic [3:0] low_cnt_r;
    logic       pin_reset_r;

    // count consecutive low cycles; any high sample restarts the count
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            low_cnt_r <= GLITCH_CYC; // pin counts as long held at power-up
        end else if (clk_en) begin
            if (!rif.pin_low)
                low_cnt_r <= GLITCH_ZERO;
            else if (low_cnt_r != GLITCH_CYC)
                low_cnt_r <= low_cnt_r + GLITCH_ONE;
        end
    end

    // request only after a full 200 ns low, release at once on high
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_reset_r <= 1'b1; // a held pin must not let the chain release early
        end else if (clk_en) begin
            pin_reset_r <= rif.pin_low && (low_cnt_r == GLITCH_CYC - GLITCH_ONE
                                           || low_cnt_r == GLITCH_CYC); // see [R10]
        end
    end

    assign rif.pin_reset = pin_reset_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_glitch_short;
        @(posedge sys_clk) disable iff (!rst_n || !clk_en)
        $rose(rif.pin_low) ##1 !rif.pin_low |-> !pin_reset_r [*2];
    endproperty
    a_glitch_short: assert property (p_glitch_short) else $error("short low pulse passed filter"); // see [R10]

    property p_glitch_long;
        @(posedge sys_clk) disable iff (!rst_n || !clk_en)
        rif.pin_low [*8] |=> pin_reset_r;
    endproperty
    a_glitch_long: assert property (p_glitch_long) else $error("long low pulse not taken"); // see [R10]

    c_glitch_taken: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(pin_reset_r));
endmodule

// >>> design/ossq_pkg.sv
// ossq_pkg: shared constants and types for the operating-state reset sequencer
// assumes a single 40 MHz sequencer clock (on-chip oscillator)
package ossq_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS     = 25000;
    localparam int unsigned GLITCH_NS         = 200;
    // least time: round up to whole cycles
    localparam int unsigned GLITCH_CYC_I      = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0]  GLITCH_CYC        = GLITCH_CYC_I[3:0];
    localparam logic [3:0]  GLITCH_ZERO       = 4'h0;
    localparam logic [3:0]  GLITCH_ONE        = 4'h1;

    // cold boot initialisation length in cycles
    localparam logic [7:0]  COLD_INIT_CYC     = 8'h40;
    // warm boot digital reset pulse length in cycles
    localparam logic [3:0]  WARM_RST_CYC      = 4'h8;
    // watchdog reset drive on the shared pin, in cycles
    localparam logic [7:0]  WDOG_PULSE_CYC    = 8'h80;
    localparam logic [7:0]  CNT8_ZERO         = 8'h00;
    localparam logic [7:0]  CNT8_ONE          = 8'h01;
    localparam logic [3:0]  CNT4_ZERO         = 4'h0;
    localparam logic [3:0]  CNT4_ONE          = 4'h1;

    // operating states
    typedef enum logic [2:0] {
        OSSQ_OFF     = 3'h0,
        OSSQ_SAFE    = 3'h1,
        OSSQ_COLD    = 3'h2,
        OSSQ_WARM    = 3'h3,
        OSSQ_OPER    = 3'h4
    } ossq_state_e;

endpackage

// >>> design/ossq_rst_if.sv
// ossq_rst_if: carries reset sources between the sequencer and its pin filter
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface ossq_rst_if;
    logic pin_low;       // raw pin level is low
    logic pin_reset;     // filtered pin reset request
    modport filt (input pin_low, output pin_reset);
    modport seq  (output pin_low, input pin_reset);
endinterface

// >>> design/ossq_sequencer.sv
// ossq_sequencer: operating-state reset sequencer top level
// assumes sys_clk is the on-chip oscillator, supply monitors and watchdog are
// synchronous levels, and the board combines reset pin enables into a wire
//
// Functional notes
// [R1] powered-off is left only to safe, and entered only from safe
// [R2] external system holds the reset pin low until supplies are stable
// [R3] internal reset stays asserted while any supply monitor reports low
// [R4] safe state: outputs tri-stated, pins input-only, processor and peripherals idle; the reset pin stays driven low in safe while a watchdog pulse runs
// [R5] cold boot initialises analog, control and debug logic; processor halted
// [R6] end of cold boot releases internal reset and enters warm boot
// [R7] warm boot resets digital logic, then enables processor to fetch boot rom
// [R8] no hardware warm boot completion; boot program requests operational state
// [R9] watchdog reset drives the shared reset pin low
// [R10] reset input low pulses under 200 ns are ignored
// [R11] watchdog counter runs from oscillator clock, independent of program flow
// [R12] input clock failure switches to limp clock for safe shutdown
// [R13] internal reset asserts asynchronously, releases synchronously to sequencer clock
`timescale 1ns/1ps
module ossq_sequencer
    import ossq_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic               supply_on,
    input  wire logic               external_cold_reset_pin_n_i,
    output logic                    external_cold_reset_pin_n_o,
    output logic                    external_cold_reset_pin_n_oe_n,
    input  wire logic               por_supply_ok,
    input  wire logic               brownout_supply_monitor_ok,
    input  wire logic               wdog_service,
    input  wire logic [15:0]        wdog_period,
    input  wire logic               wdog_enable,
    input  wire logic               input_clk_fail,
    input  wire logic               boot_done_req,
    output logic                    internal_system_reset_n,
    output logic                    digital_reset_n,
    output logic                    init_busy,
    output logic                    cpu_enable,
    output logic                    periph_enable,
    output logic                    io_drive_enable,
    output logic                    limp_clk_sel,
    output logic                    wdog_reset,
    output ossq_pkg::ossq_state_e   op_state
);
    import ossq_pkg::*;

    // ------------------------------------------------------------------
    // pin filter
    // ------------------------------------------------------------------
    ossq_rst_if rif ();
    assign rif.pin_low = !external_cold_reset_pin_n_i;

    ossq_deglitch u_ossq_deglitch (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .rif     (rif)
    );

    // ------------------------------------------------------------------
    // reset source combination
    // ------------------------------------------------------------------
    logic supply_bad;
    logic any_reset;
    logic sysrst_meta_r;
    logic sysrst_n_r;

    // monitors keep reset asserted even after the pin releases
    assign supply_bad = !por_supply_ok || !brownout_supply_monitor_ok; // see [R3]
    assign any_reset  = supply_bad || rif.pin_reset || wdog_reset;

    // release is staged over two flops so every state register leaves reset
    // together; assertion bypasses the clock entirely
    always_ff @(posedge sys_clk or posedge any_reset) begin
        if (any_reset) begin
            sysrst_meta_r <= 1'b0; // see [R13]
            sysrst_n_r    <= 1'b0;
        end else if (!rst_n) begin
            sysrst_meta_r <= 1'b0;
            sysrst_n_r    <= 1'b0;
        end else if (clk_en) begin
            sysrst_meta_r <= 1'b1;
            sysrst_n_r    <= sysrst_meta_r; // see [R13]
        end
    end

    // ------------------------------------------------------------------
    // operating state machine
    // ------------------------------------------------------------------
    ossq_state_e state_r;
    ossq_state_e state_nxt;
    logic [7:0]  cold_cnt_r;
    logic [3:0]  warm_cnt_r;
    logic        cold_done;
    logic        warm_rst_done;

    // entry cycle counts as the first cold cycle
    assign cold_done     = (cold_cnt_r == COLD_INIT_CYC - CNT8_ONE);
    assign warm_rst_done = (warm_cnt_r == WARM_RST_CYC);

    // next state; any reset source pulls back to safe
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            OSSQ_OFF: begin
                if (supply_on)
                    state_nxt = OSSQ_SAFE; // see [R1]
            end
            OSSQ_SAFE: begin
                if (!supply_on)
                    state_nxt = OSSQ_OFF; // see [R1]
                else if (sysrst_n_r)
                    state_nxt = OSSQ_COLD;
            end
            OSSQ_COLD: begin
                if (cold_done)
                    state_nxt = OSSQ_WARM; // see [R6]
            end
            OSSQ_WARM: begin
                if (boot_done_req && warm_rst_done)
                    state_nxt = OSSQ_OPER; // see [R8]
            end
            OSSQ_OPER: begin
                state_nxt = OSSQ_OPER;
            end
            default: state_nxt = OSSQ_SAFE;
        endcase
        // reset and supply loss always route through safe, never straight off
        if (state_r != OSSQ_OFF && (!sysrst_n_r || !supply_on) && state_r != OSSQ_SAFE)
            state_nxt = OSSQ_SAFE; // see [R1]
    end

    // state register; rst_n is the sequencer's own power-up reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            state_r <= OSSQ_OFF;
        else if (clk_en)
            state_r <= state_nxt;
    end

    // cold boot initialisation timer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cold_cnt_r <= CNT8_ZERO;
        end else if (clk_en) begin
            if (state_r != OSSQ_COLD)
                cold_cnt_r <= CNT8_ZERO;
            else if (!cold_done)
                cold_cnt_r <= cold_cnt_r + CNT8_ONE; // see [R5]
        end
    end

    // warm boot digital reset pulse before the processor starts; held
    // through operational so the processor is not dropped again
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            warm_cnt_r <= CNT4_ZERO;
        end else if (clk_en) begin
            if (state_r != OSSQ_WARM && state_r != OSSQ_OPER)
                warm_cnt_r <= CNT4_ZERO;
            else if (!warm_rst_done)
                warm_cnt_r <= warm_cnt_r + CNT4_ONE; // see [R7]
        end
    end

    // ------------------------------------------------------------------
    // state-driven controls
    // ------------------------------------------------------------------
    logic in_run;
    logic run_gate_r;
    assign in_run = (state_nxt == OSSQ_WARM) || (state_nxt == OSSQ_OPER);

    // controls decode the next state so they change with op_state; a decode
    // of the current state would leave drivers on for one cycle in safe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            run_gate_r              <= 1'b0;
            digital_reset_n         <= 1'b0;
            init_busy               <= 1'b0;
            cpu_enable              <= 1'b0;
            periph_enable           <= 1'b0;
            io_drive_enable         <= 1'b0;
        end else if (clk_en) begin
            run_gate_r              <= in_run;                             // see [R6]
            init_busy               <= (state_nxt == OSSQ_COLD);           // see [R5]
            digital_reset_n         <= in_run && warm_rst_done;            // see [R7]
            cpu_enable              <= in_run && warm_rst_done;            // see [R7]
            periph_enable           <= (state_nxt == OSSQ_OPER);           // see [R4]
            io_drive_enable         <= in_run;                             // see [R4]
        end
    end

    // held through cold boot; falls with the release chain, no clock needed
    assign internal_system_reset_n = sysrst_n_r && run_gate_r; // see [R13]

    // ------------------------------------------------------------------
    // clock fail handling
    // ------------------------------------------------------------------
    // once switched, stay on limp clock until power cycle; no glitchy return
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            limp_clk_sel <= 1'b0;
        else if (clk_en && input_clk_fail)
            limp_clk_sel <= 1'b1; // see [R12]
    end

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    logic [15:0] wdog_cnt_r;
    logic [7:0]  wdog_pulse_r;

    // counts on the oscillator clock regardless of what the processor runs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wdog_cnt_r <= 16'h0000;
        end else if (clk_en) begin
            if (!wdog_enable || !cpu_enable || wdog_service || wdog_reset)
                wdog_cnt_r <= 16'h0000;
            else
                wdog_cnt_r <= wdog_cnt_r + 16'h0001; // see [R11]
        end
    end

    // timeout starts a fixed-length reset pulse
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wdog_pulse_r <= CNT8_ZERO;
        end else if (clk_en) begin
            if (wdog_pulse_r != CNT8_ZERO)
                wdog_pulse_r <= wdog_pulse_r - CNT8_ONE;
            else if (wdog_enable && cpu_enable && !wdog_service && wdog_cnt_r >= wdog_period)
                wdog_pulse_r <= WDOG_PULSE_CYC; // see [R11]
        end
    end

    assign wdog_reset = (wdog_pulse_r != CNT8_ZERO);

    // open-drain style: drive low only for watchdog reset, else release
    assign external_cold_reset_pin_n_o    = 1'b0;
    assign external_cold_reset_pin_n_oe_n = !wdog_reset; // see [R9]

    assign op_state = state_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_off_exit;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(state_r) == OSSQ_OFF && state_r != OSSQ_OFF |-> state_r == OSSQ_SAFE;
    endproperty
    a_off_exit: assert property (p_off_exit) else $error("off left to non-safe state"); // see [R1]

    property p_off_entry;
        @(posedge sys_clk) disable iff (!rst_n)
        state_r != OSSQ_OFF ##1 state_r == OSSQ_OFF |-> $past(state_r) == OSSQ_SAFE;
    endproperty
    a_off_entry: assert property (p_off_entry) else $error("off entered from non-safe state"); // see [R1]

    property p_supply_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        supply_bad |-> !internal_system_reset_n;
    endproperty
    a_supply_hold: assert property (p_supply_hold) else $error("reset released under bad supply"); // see [R3]

    property p_safe_quiet;
        @(posedge sys_clk) disable iff (!rst_n || !clk_en)
        state_r == OSSQ_SAFE |-> !io_drive_enable && !cpu_enable && !periph_enable;
    endproperty
    a_safe_quiet: assert property (p_safe_quiet) else $error("safe state not quiet"); // see [R4]

    property p_cold_halted;
        @(posedge sys_clk) disable iff (!rst_n)
        state_r == OSSQ_COLD |-> !cpu_enable && !periph_enable;
    endproperty
    a_cold_halted: assert property (p_cold_halted) else $error("processor ran in cold boot"); // see [R5]

    property p_cold_to_warm;
        @(posedge sys_clk) disable iff (!rst_n || !clk_en)
        state_r == OSSQ_COLD && cold_done && sysrst_n_r && supply_on |=> state_r == OSSQ_WARM;
    endproperty
    a_cold_to_warm: assert property (p_cold_to_warm) else $error("cold boot did not advance"); // see [R6]

    property p_warm_order;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(cpu_enable) |-> $past(state_r) != OSSQ_COLD && warm_rst_done;
    endproperty
    a_warm_order: assert property (p_warm_order) else $error("processor enabled before digital reset"); // see [R7]

    property p_no_auto_oper;
        @(posedge sys_clk) disable iff (!rst_n)
        state_r == OSSQ_WARM && !boot_done_req |=> state_r != OSSQ_OPER;
    endproperty
    a_no_auto_oper: assert property (p_no_auto_oper) else $error("operational without boot request"); // see [R8]

    property p_wdog_pin;
        @(posedge sys_clk) disable iff (!rst_n)
        wdog_reset |-> !external_cold_reset_pin_n_oe_n && !external_cold_reset_pin_n_o;
    endproperty
    a_wdog_pin: assert property (p_wdog_pin) else $error("watchdog reset not driven on pin"); // see [R9]

    property p_limp;
        @(posedge sys_clk) disable iff (!rst_n || !clk_en)
        input_clk_fail |=> limp_clk_sel;
    endproperty
    a_limp: assert property (p_limp) else $error("limp clock not selected"); // see [R12]

    c_reach_oper: cover property (@(posedge sys_clk) disable iff (!rst_n) state_r == OSSQ_OPER);
    c_wdog_fire:  cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(wdog_reset));
    c_back_off:   cover property (@(posedge sys_clk) disable iff (!rst_n)
                                  state_r == OSSQ_SAFE ##1 state_r == OSSQ_OFF);
endmodule

// >>> tb/ossq_rst_partner.sv
// ossq_rst_partner: external reset supervisor and the shared open-drain reset line
// assumes the device pulls the line low while its active-low output enable is low
`timescale 1ns/1ps
module ossq_rst_partner #(
    parameter int RAMP_CYC = 16
) (
    input  wire logic sys_clk,
    input  wire logic supply_on,
    input  wire logic dev_oe_n,
    output logic      pin_n
);
    logic hold_low_r;
    logic pulse_low_r;
    int   ramp_cnt;

    // ------------------------------------------------------------------
    // supervisor
    // ------------------------------------------------------------------
    initial begin
        hold_low_r  = 1'b1;
        pulse_low_r = 1'b0;
        ramp_cnt    = 0;
    end

    // line stays low until the supplies have had time to ramp
    always @(posedge sys_clk) begin
        if (!supply_on) begin
            ramp_cnt   <= 0;
            hold_low_r <= 1'b1;
        end else if (ramp_cnt < RAMP_CYC) begin
            ramp_cnt <= ramp_cnt + 1;
        end else begin
            hold_low_r <= 1'b0;
        end
    end

    // pull-up: the line is high unless some party pulls it down
    assign pin_n = (hold_low_r || pulse_low_r || !dev_oe_n) ? 1'b0 : 1'b1;

    // low pulse of n cycles, launched and ended on rising edges
    task automatic pulse_low(input int n);
        @(posedge sys_clk);
        pulse_low_r <= 1'b1;
        repeat (n) @(posedge sys_clk);
        pulse_low_r <= 1'b0;
    endtask
endmodule

// >>> tb/ossq_sequencer_tb.sv
// ossq_sequencer_tb: self-checking bench for the operating-state reset sequencer
// assumes one 40 MHz clock; inputs change on rising edges, outputs are read on falling edges
`timescale 1ns/1ps
module ossq_sequencer_tb;
    import ossq_pkg::*;

    logic        sys_clk, rst_n, supply_on, por_ok, bor_ok, wdog_service, wdog_enable, clk_fail, boot_req;
    logic [15:0] wdog_period;
    logic        pin_n, pin_o, oe_n, sys_rst_n, dig_rst_n, init_busy, cpu_en, per_en, io_en, limp, wdog_rst;
    ossq_state_e op_state, prev_st;
    int          error_cnt, checked;

    initial begin
        sys_clk = 0; rst_n = 0; supply_on = 0; por_ok = 0; bor_ok = 0; wdog_service = 0;
        wdog_enable = 0; clk_fail = 0; boot_req = 0; wdog_period = 16'h0020; error_cnt = 0; checked = 0;
    end
    always #12.5 sys_clk = ~sys_clk;

    ossq_rst_partner u_ossq_rst_partner (.sys_clk(sys_clk), .supply_on(supply_on), .dev_oe_n(oe_n), .pin_n(pin_n));

    ossq_sequencer u_ossq_sequencer (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .supply_on(supply_on),
        .external_cold_reset_pin_n_i(pin_n), .external_cold_reset_pin_n_o(pin_o),
        .external_cold_reset_pin_n_oe_n(oe_n), .por_supply_ok(por_ok), .brownout_supply_monitor_ok(bor_ok),
        .wdog_service(wdog_service), .wdog_period(wdog_period), .wdog_enable(wdog_enable),
        .input_clk_fail(clk_fail), .boot_done_req(boot_req), .internal_system_reset_n(sys_rst_n),
        .digital_reset_n(dig_rst_n), .init_busy(init_busy), .cpu_enable(cpu_en), .periph_enable(per_en),
        .io_drive_enable(io_en), .limp_clk_sel(limp), .wdog_reset(wdog_rst), .op_state(op_state));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    task automatic wait_st(input ossq_state_e st, input int n);
        for (int i = 0; i < n && op_state !== st; i++) @(negedge sys_clk);
        chk(op_state === st, "state not reached in time");
    endtask

    // boot program side: wait for the processor, then ask for operational
    task automatic boot_to_oper();
        wait_st(OSSQ_WARM, 400);
        for (int i = 0; i < 20 && cpu_en !== 1'b1; i++) @(negedge sys_clk);
        @(posedge sys_clk) boot_req <= 1'b1;
        @(posedge sys_clk) boot_req <= 1'b0;
        wait_st(OSSQ_OPER, 4);
        @(negedge sys_clk) chk(per_en === 1'b1 && io_en === 1'b1, "peripherals not enabled");
    endtask

    // powered-off is only entered from, and only left to, safe
    always @(negedge sys_clk) begin
        if (rst_n === 1'b1 && op_state !== prev_st) begin
            if (op_state === OSSQ_OFF) chk(prev_st === OSSQ_SAFE, "off entered not from safe");
            if (prev_st === OSSQ_OFF) chk(op_state === OSSQ_SAFE, "off left not to safe");
        end
        if (op_state === OSSQ_SAFE) chk({io_en, cpu_en, per_en} === 3'b000, "safe state not quiet");
        prev_st <= op_state;
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_power_up();
        int n;
        chk(op_state === OSSQ_OFF && oe_n === 1'b1 && sys_rst_n === 1'b0, "reset values");
        @(posedge sys_clk) {supply_on, por_ok, bor_ok} <= 3'b111;
        wait_st(OSSQ_SAFE, 3);
        // supervisor still holds the pin through its ramp: safe every cycle
        repeat (14) @(negedge sys_clk)
            chk(op_state === OSSQ_SAFE && sys_rst_n === 1'b0, "left safe while pin held");
        wait_st(OSSQ_COLD, 40);
        chk(init_busy === 1'b1 && sys_rst_n === 1'b0 && cpu_en === 1'b0 && per_en === 1'b0,
            "cold boot outputs");
        @(posedge sys_clk) boot_req <= 1'b1; // refused outside warm boot
        @(posedge sys_clk) boot_req <= 1'b0;
        n = 2; // two cold cycles already seen before this sample
        @(negedge sys_clk);
        while (op_state === OSSQ_COLD && n < 200) begin
            n++;
            @(negedge sys_clk);
        end
        chk(n == int'(COLD_INIT_CYC), "cold boot length");
        chk(op_state === OSSQ_WARM && sys_rst_n === 1'b1, "cold boot exit");
        chk(cpu_en === 1'b0, "cpu enabled before digital reset");
        n = 0;
        while (cpu_en !== 1'b1 && n < 20) begin
            n++;
            @(negedge sys_clk);
        end
        chk(n >= int'(WARM_RST_CYC) && n < 20 && dig_rst_n === 1'b1, "warm reset span");
        boot_to_oper();
        $display("test power_up done");
    endtask

    task automatic test_glitch();
        u_ossq_rst_partner.pulse_low(int'(GLITCH_CYC) - 1);
        repeat (6) @(negedge sys_clk);
        chk(op_state === OSSQ_OPER, "short pin pulse reset the device");
        u_ossq_rst_partner.pulse_low(int'(GLITCH_CYC) + 4);
        wait_st(OSSQ_SAFE, 6);
        chk(sys_rst_n === 1'b0, "long pin pulse ignored");
        boot_to_oper();
        $display("test glitch done");
    endtask

    task automatic test_brownout();
        @(posedge sys_clk) bor_ok <= 1'b0;
        wait_st(OSSQ_SAFE, 6);
        repeat (40) @(negedge sys_clk) chk(sys_rst_n === 1'b0 && op_state === OSSQ_SAFE, "reset released");
        @(posedge sys_clk) bor_ok <= 1'b1;
        boot_to_oper();
        $display("test brownout done");
    endtask

    task automatic test_watchdog();
        int n;
        @(posedge sys_clk) wdog_enable <= 1'b1;
        repeat (8) begin
            repeat (16) @(posedge sys_clk);
            wdog_service <= 1'b1;
            @(posedge sys_clk) wdog_service <= 1'b0;
        end
        chk(wdog_rst === 1'b0 && op_state === OSSQ_OPER, "serviced watchdog fired");
        for (n = 0; n < 80 && wdog_rst !== 1'b1; n++) @(negedge sys_clk);
        chk(wdog_rst === 1'b1 && oe_n === 1'b0 && pin_o === 1'b0 && pin_n === 1'b0, "watchdog pin drive");
        @(posedge sys_clk) wdog_enable <= 1'b0;
        n = 0;
        while (wdog_rst === 1'b1 && n < 300) begin
            n++;
            @(negedge sys_clk);
        end
        chk(n == int'(WDOG_PULSE_CYC) && oe_n === 1'b1, "watchdog pulse length");
        chk(op_state !== OSSQ_OPER, "watchdog did not reset");
        boot_to_oper();
        $display("test watchdog done");
    endtask

    task automatic test_limp_and_off();
        chk(limp === 1'b0, "limp clock selected without a failure");
        @(posedge sys_clk) clk_fail <= 1'b1;
        @(posedge sys_clk) clk_fail <= 1'b0;
        repeat (10) @(negedge sys_clk);
        chk(limp === 1'b1 && op_state === OSSQ_OPER, "limp clock not held");
        @(posedge sys_clk) supply_on <= 1'b0;
        wait_st(OSSQ_OFF, 20);
        $display("test limp_and_off done");
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(25ns * 20000);
        error_cnt++;
        $display("FAIL %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        test_power_up();
        test_glitch();
        test_brownout();
        test_watchdog();
        test_limp_and_off();
        complete_run();
    end
endmodule
